// ### rtl/swcu_top.sv
// Serial command unit for one digital potentiometer
//
// Contract
// - Write protect low blocks nonvolatile writes
// - Sample serial input on rising clock
// - Serial output tri-stated when not driving
// - Exactly one tap switch on
// - Decode wiper position to one-of-256
// - Wiper changes only by four causes
// - Power-up loads wiper from default setting
// - Nonvolatile write finishes within 10ms
// - Each setting register holds 8 bits
// - Status byte returns write busy flag
// - First byte is identification, type checked
// - Address bits must match address pins
// - Second byte: opcode, register, bank
// - Sixteen registers as four banks
// - Wiper transfers only with bank zero
// - Data commands use three-byte frames
// - Transfers use two-byte frames
// - Setting-to-wiper moves after settle delay
// - Wiper-to-setting is timed nonvolatile write
// - Increment/decrement steps per clock by input
// - Save starts at select rise, busy set
// - Read data changes on falling clock
// - Hold pauses frame, state kept
// - Decode the eight opcodes
// - Deselected while select high
`timescale 1ns/1ps
module swcu_top #(
    parameter int NV_CYCLES = swcu_pkg::NV_WRITE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_write_protect_n,
    input wire logic i_addr_pin_hi,
    input wire logic i_addr_pin_lo,
    output logic o_so,
    output logic o_so_oe,
    output logic [255:0] o_tap_sel,
    output logic [7:0] o_wiper_position,
    output logic o_write_busy_flag
);
    import swcu_pkg::*;

    // Two-flop synchronisers for all pins
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] sync3;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1 <= 7'h70;
            sync2 <= 7'h70;
            sync3 <= 7'h70;
        end else begin
            sync1 <= {i_hold_n, i_write_protect_n, i_cs_n, i_sck, i_si, i_addr_pin_hi, i_addr_pin_lo};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    logic cs_n_s, sck_s, si_s, wp_n_s, hold_n_s, addr_hi_s, addr_lo_s;
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    assign hold_n_s = sync2[6];
    assign wp_n_s = sync2[5];
    assign cs_n_s = sync2[4];
    assign sck_s = sync2[3];
    assign si_s = sync2[2];
    assign addr_hi_s = sync2[1];
    assign addr_lo_s = sync2[0];
    // Hold freezes edges so the frame survives a pause
    assign sck_rise = sck_s & ~sync3[3] & ~cs_n_s & hold_n_s;
    assign sck_fall = ~sck_s & sync3[3] & ~cs_n_s & hold_n_s;
    assign cs_fall = ~cs_n_s & sync3[4];
    assign cs_rise = cs_n_s & ~sync3[4];

    // Nonvolatile contents survive reset; only register 0 gets a default
    logic [7:0] setting_store [0:15] = '{0: DEFAULT_SETTING_RESET, default: 8'h00};
    logic [3:0] save_idx, next_save_idx;
    logic [7:0] save_val, next_save_val;

    swcu_state_t state;
    swcu_state_t next_state;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bitcnt, next_bitcnt;
    logic [3:0] opcode, next_opcode;
    logic [3:0] sel, next_sel;
    logic [7:0] wiper, next_wiper;
    logic [7:0] txreg, next_txreg;
    logic so, next_so;
    logic so_oe, next_so_oe;
    logic [7:0] pend_data, next_pend_data;
    logic pend_save, next_pend_save;
    logic [23:0] nv_cnt, next_nv_cnt;
    logic busy, next_busy;
    logic [7:0] settle_cnt, next_settle_cnt;
    logic [7:0] settle_val, next_settle_val;
    logic recalled, next_recalled;
    logic store_we;
    logic [7:0] byte_in;

    assign byte_in = {shreg[6:0], si_s};

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_opcode = opcode;
        next_sel = sel;
        next_wiper = wiper;
        next_txreg = txreg;
        next_so = so;
        next_so_oe = so_oe;
        next_pend_data = pend_data;
        next_pend_save = pend_save;
        next_nv_cnt = nv_cnt;
        next_busy = busy;
        next_settle_cnt = settle_cnt;
        next_settle_val = settle_val;
        next_recalled = 1'b1;
        store_we = 1'b0;
        next_save_idx = save_idx;
        next_save_val = save_val;
        if (!recalled) begin
            next_wiper = setting_store[0];
        end
        if (settle_cnt != 8'h00) begin
            next_settle_cnt = settle_cnt - 8'h01;
            if (settle_cnt == 8'h01) begin
                next_wiper = settle_val;
            end
        end
        if (busy) begin
            if (nv_cnt == 24'h000001) begin
                next_busy = 1'b0;
                store_we = 1'b1;
            end
            next_nv_cnt = nv_cnt - 24'h000001;
        end
        if (cs_n_s) begin
            next_state = SWCU_IDLE;
            next_so_oe = 1'b0;
        end
        if (cs_fall) begin
            next_state = SWCU_ID;
            next_bitcnt = 3'h0;
            next_pend_save = 1'b0;
        end
        if (cs_rise && pend_save && !busy && wp_n_s) begin
            next_busy = 1'b1;
            next_nv_cnt = NV_CYCLES[23:0];
            // Latched so later frames during the save cannot retarget it
            next_save_idx = sel;
            next_save_val = pend_data;
            next_pend_save = 1'b0;
        end
        if (sck_rise) begin
            next_shreg = byte_in;
            next_bitcnt = bitcnt + 3'h1;
            case (state)
                SWCU_ID: begin
                    if (bitcnt == 3'h7) begin
                        if (byte_in[7:4] == DEVICE_TYPE_FIELD && byte_in[1] == addr_hi_s
                                && byte_in[0] == addr_lo_s) begin
                            next_state = SWCU_INSTR;
                        end else begin
                            next_state = SWCU_IGNORE;
                        end
                    end
                end
                SWCU_INSTR: begin
                    if (bitcnt == 3'h7) begin
                        next_opcode = byte_in[7:4];
                        next_sel = {byte_in[1:0], byte_in[3:2]};
                        next_state = SWCU_DATA;
                        case (byte_in[7:4])
                            OP_READ_WIPER: next_txreg = wiper;
                            OP_READ_SETTING: next_txreg = setting_store[{byte_in[1:0], byte_in[3:2]}];
                            OP_STATUS_READ: next_txreg = {7'h00, busy};
                            OP_WRITE_WIPER, OP_WRITE_SETTING: next_txreg = 8'h00;
                            OP_INC_DEC: next_state = SWCU_INCDEC;
                            OP_SETTING_TO_WIPER: begin
                                next_state = SWCU_DONE;
                                if (byte_in[1:0] == 2'b00) begin
                                    next_settle_val = setting_store[{2'b00, byte_in[3:2]}];
                                    next_settle_cnt = WIPER_SETTLE_CYCLES[7:0];
                                end
                            end
                            OP_WIPER_TO_SETTING: begin
                                next_state = SWCU_DONE;
                                if (byte_in[1:0] == 2'b00) begin
                                    next_pend_data = wiper;
                                    next_pend_save = 1'b1;
                                end
                            end
                            default: next_state = SWCU_IGNORE;
                        endcase
                    end
                end
                SWCU_DATA: begin
                    if (bitcnt == 3'h7) begin
                        next_state = SWCU_DONE;
                        if (opcode == OP_WRITE_WIPER) begin
                            next_wiper = byte_in;
                        end else if (opcode == OP_WRITE_SETTING) begin
                            next_pend_data = byte_in;
                            next_pend_save = 1'b1;
                        end
                    end
                end
                SWCU_INCDEC: begin
                    if (si_s && wiper != WIPER_MAX) begin
                        next_wiper = wiper + 8'h01;
                    end else if (!si_s && wiper != WIPER_MIN) begin
                        next_wiper = wiper - 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end
        if (sck_fall) begin
            if (state == SWCU_DATA && (opcode == OP_READ_WIPER || opcode == OP_READ_SETTING
                    || opcode == OP_STATUS_READ)) begin
                next_so_oe = 1'b1;
                next_so = txreg[7];
                next_txreg = {txreg[6:0], 1'b0};
            end else begin
                next_so_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= SWCU_IDLE;
            shreg <= 8'h00;
            bitcnt <= 3'h0;
            opcode <= 4'h0;
            sel <= 4'h0;
            wiper <= 8'h00;
            txreg <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
            save_idx <= 4'h0;
            save_val <= 8'h00;
            pend_data <= 8'h00;
            pend_save <= 1'b0;
            nv_cnt <= 24'h000000;
            busy <= 1'b0;
            settle_cnt <= 8'h00;
            settle_val <= 8'h00;
            recalled <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            opcode <= next_opcode;
            sel <= next_sel;
            wiper <= next_wiper;
            txreg <= next_txreg;
            so <= next_so;
            so_oe <= next_so_oe;
            save_idx <= next_save_idx;
            save_val <= next_save_val;
            pend_data <= next_pend_data;
            pend_save <= next_pend_save;
            nv_cnt <= next_nv_cnt;
            busy <= next_busy;
            settle_cnt <= next_settle_cnt;
            settle_val <= next_settle_val;
            recalled <= next_recalled;
        end
    end

    always_ff @(posedge i_clk) begin
        if (store_we) begin
            setting_store[save_idx] <= save_val;
        end
    end

    logic [255:0] next_tap;
    always_comb begin
        next_tap = 256'h0;
        next_tap[next_wiper] = 1'b1;
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_tap_sel <= 256'h1;
            o_wiper_position <= 8'h00;
            o_write_busy_flag <= 1'b0;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else begin
            o_tap_sel <= next_tap;
            o_wiper_position <= next_wiper;
            o_write_busy_flag <= next_busy;
            o_so <= next_so;
            o_so_oe <= next_so_oe & ~next_state[2] | next_so_oe & (next_state == SWCU_DATA);
        end
    end

    a_tap_onehot: assert property (@(posedge i_clk) disable iff (i_reset)
        $onehot(o_tap_sel) && o_tap_sel[o_wiper_position]) else $error("tap select not matching");
    a_busy_len: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(busy) |-> busy[*8]) else $error("busy too short");
    a_wp_block: assert property (@(posedge i_clk) disable iff (i_reset)
        !wp_n_s && cs_rise && !busy |=> !busy) else $error("write under protect");
    a_so_desel: assert property (@(posedge i_clk) disable iff (i_reset)
        cs_n_s |=> !so_oe) else $error("output driven deselected");
    a_sat_top: assert property (@(posedge i_clk) disable iff (i_reset)
        state == SWCU_INCDEC && sck_rise && si_s && wiper == WIPER_MAX |=> wiper == WIPER_MAX)
        else $error("wiper wrapped up");
    a_sat_bot: assert property (@(posedge i_clk) disable iff (i_reset)
        state == SWCU_INCDEC && sck_rise && !si_s && wiper == WIPER_MIN |=> wiper == WIPER_MIN)
        else $error("wiper wrapped down");
    a_ignore_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
        state == SWCU_IGNORE |=> !so_oe) else $error("ignored frame drove output");
    a_recall: assert property (@(posedge i_clk) disable iff (i_reset)
        !recalled |=> wiper == $past(setting_store[0])) else $error("no recall");
    a_status_bit: assert property (@(posedge i_clk) disable iff (i_reset)
        state == SWCU_INSTR && sck_rise && bitcnt == 3'h7 && byte_in[7:4] == OP_STATUS_READ
        |=> txreg == {7'h00, $past(busy)}) else $error("status byte mismatch");
    c_write_save: cover property (@(posedge i_clk) $rose(busy));
    c_incdec: cover property (@(posedge i_clk) state == SWCU_INCDEC && sck_rise);
    c_read: cover property (@(posedge i_clk) $rose(so_oe));
    c_ignore: cover property (@(posedge i_clk) state == SWCU_IGNORE);
endmodule : swcu_top

// ### rtl/swcu_pkg.sv
// Constants and types for the serial wiper command unit
package swcu_pkg;
    // Type code value is arbitrary
    localparam logic [3:0] DEVICE_TYPE_FIELD = 4'ha;
    localparam logic [3:0] OP_READ_WIPER = 4'h9;
    localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
    localparam logic [3:0] OP_READ_SETTING = 4'hb;
    localparam logic [3:0] OP_WRITE_SETTING = 4'hc;
    localparam logic [3:0] OP_SETTING_TO_WIPER = 4'hd;
    localparam logic [3:0] OP_WIPER_TO_SETTING = 4'he;
    localparam logic [3:0] OP_INC_DEC = 4'h2;
    localparam logic [3:0] OP_STATUS_READ = 4'h5;
    localparam int CLK_PERIOD_NS = 5;
    localparam int NV_WRITE_TIME_US = 10000;
    localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int WIPER_SETTLE_TIME_NS = 100;
    localparam int WIPER_SETTLE_CYCLES = (WIPER_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] DEFAULT_SETTING_RESET = 8'h80;
    localparam logic [7:0] WIPER_MAX = 8'hff;
    localparam logic [7:0] WIPER_MIN = 8'h00;
    typedef enum logic [2:0] {
        SWCU_IDLE = 3'b000,
        SWCU_ID = 3'b001,
        SWCU_INSTR = 3'b010,
        SWCU_DATA = 3'b011,
        SWCU_INCDEC = 3'b100,
        SWCU_DONE = 3'b101,
        SWCU_IGNORE = 3'b110
    } swcu_state_t;
endpackage : swcu_pkg

// ### verif/swcu_host.sv
// Host serial master model for the wiper command unit
`timescale 1ns/1ps
module swcu_host (
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_n
);
    // Pin edges land off the clk grid, so no race with sampling
    localparam realtime HALF = 32.0;
    logic saw_drive;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
        saw_drive = 1'b0;
    end
    always @(posedge i_clk) begin
        if (i_so_oe === 1'b1) begin
            saw_drive = 1'b1;
        end
    end
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_si = tx[i];
            #HALF;
            // Released line reads as the inverse of the bit being sent
            rx[i] = i_so_oe ? i_so : ~o_si;
            o_sck = 1'b1;
            #HALF;
            o_sck = 1'b0;
        end
    endtask : byte_io
    task automatic open_frame(input logic [7:0] id, input logic [7:0] instr);
        logic [7:0] rx;
        @(posedge i_clk);
        #1.25;
        saw_drive = 1'b0;
        o_cs_n = 1'b0;
        #HALF;
        byte_io(id, rx);
        byte_io(instr, rx);
    endtask : open_frame
    task automatic close_frame();
        #HALF;
        o_cs_n = 1'b1;
        o_si = ~o_si;
    endtask : close_frame
    task automatic frame(input logic [7:0] id, input logic [7:0] instr, input logic [7:0] tx,
                         input bit data, output logic [7:0] rx);
        rx = 8'h00;
        open_frame(id, instr);
        if (data) begin
            byte_io(tx, rx);
        end
        close_frame();
        #(6 * HALF);
    endtask : frame
    task automatic pause(input int pulses);
        // Lower hold clear of the last falling edge
        #HALF;
        o_hold_n = 1'b0;
        repeat (pulses) begin
            #HALF;
            o_sck = 1'b1;
            #HALF;
            o_sck = 1'b0;
        end
        #HALF;
        o_hold_n = 1'b1;
        #HALF;
    endtask : pause
endmodule : swcu_host

// ### verif/test_swcu_top.sv
// Self-checking bench for the serial wiper command unit
`timescale 1ns/1ps
module test_swcu_top;
    import swcu_pkg::*;
    // Short save time keeps the run small
    localparam int NV = 400;
    localparam int LIMIT = 60000;
    localparam logic [7:0] ID_OK = {DEVICE_TYPE_FIELD, 4'h2};
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_write_protect_n = 1'b1;
    logic i_addr_pin_hi = 1'b1;
    logic i_addr_pin_lo = 1'b0;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic o_so;
    logic o_so_oe;
    logic o_write_busy_flag;
    logic [255:0] o_tap_sel;
    logic [7:0] o_wiper_position;
    logic [7:0] rx;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    swcu_top #(.NV_CYCLES(NV)) u_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .i_hold_n(hold_n), .i_write_protect_n(i_write_protect_n), .i_addr_pin_hi(i_addr_pin_hi),
        .i_addr_pin_lo(i_addr_pin_lo), .o_so(o_so), .o_so_oe(o_so_oe), .o_tap_sel(o_tap_sel),
        .o_wiper_position(o_wiper_position), .o_write_busy_flag(o_write_busy_flag)
    );
    swcu_host u_host (
        .i_clk(i_clk), .i_so(o_so), .i_so_oe(o_so_oe), .o_cs_n(cs_n), .o_sck(sck),
        .o_si(si), .o_hold_n(hold_n)
    );
    always #2.5 i_clk = ~i_clk;
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            summarize();
        end
    end
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wiper_is(input logic [7:0] v);
        check(o_wiper_position, v);
        check(o_tap_sel, 256'(1) << v);
    endtask : wiper_is
    task automatic set_wiper(input logic [7:0] v);
        u_host.frame(ID_OK, {OP_WRITE_WIPER, 4'h0}, v, 1'b1, rx);
    endtask : set_wiper
    task automatic wait_idle();
        int n;
        n = 0;
        while (o_write_busy_flag !== 1'b0 && n < NV) begin
            @(posedge i_clk);
            n++;
        end
        check(o_write_busy_flag, 1'b0);
    endtask : wait_idle
    task automatic t_wiper();
        logic [7:0] vals [3];
        vals = '{8'h00, 8'h3c, 8'hff};
        for (int i = 0; i < 3; i++) begin
            set_wiper(vals[i]);
            wiper_is(vals[i]);
            u_host.frame(ID_OK, {OP_READ_WIPER, 4'h0}, 8'h00, 1'b1, rx);
            check(rx, vals[i]);
            check(u_host.saw_drive, 1'b1);
            check(o_so_oe, 1'b0);
        end
    endtask : t_wiper
    task automatic t_settings();
        logic [7:0] v;
        for (int k = 0; k < 16; k++) begin
            v = {k[3:0], ~k[3:0]};
            u_host.frame(ID_OK, {OP_WRITE_SETTING, k[1:0], k[3:2]}, v, 1'b1, rx);
            check(o_write_busy_flag, 1'b1);
            u_host.frame(ID_OK, {OP_STATUS_READ, 4'h1}, 8'h00, 1'b1, rx);
            check(rx, 8'h01);
            wait_idle();
            u_host.frame(ID_OK, {OP_STATUS_READ, 4'h1}, 8'h00, 1'b1, rx);
            check(rx, 8'h00);
            u_host.frame(ID_OK, {OP_READ_SETTING, k[1:0], k[3:2]}, 8'h00, 1'b1, rx);
            check(rx, v);
        end
    endtask : t_settings
    task automatic t_protect();
        @(posedge i_clk);
        i_write_protect_n <= 1'b0;
        u_host.frame(ID_OK, {OP_WRITE_SETTING, 2'd1, 2'd1}, 8'h00, 1'b1, rx);
        check(o_write_busy_flag, 1'b0);
        @(posedge i_clk);
        i_write_protect_n <= 1'b1;
        u_host.frame(ID_OK, {OP_READ_SETTING, 2'd1, 2'd1}, 8'h00, 1'b1, rx);
        check(rx, 8'h5a);
    endtask : t_protect
    task automatic t_transfer();
        set_wiper(8'h6c);
        u_host.frame(ID_OK, {OP_WIPER_TO_SETTING, 2'd2, 2'd0}, 8'h00, 1'b0, rx);
        check(o_write_busy_flag, 1'b1);
        wait_idle();
        u_host.frame(ID_OK, {OP_READ_SETTING, 2'd2, 2'd0}, 8'h00, 1'b1, rx);
        check(rx, 8'h6c);
        set_wiper(8'h00);
        u_host.frame(ID_OK, {OP_SETTING_TO_WIPER, 2'd2, 2'd1}, 8'h00, 1'b0, rx);
        wiper_is(8'h00);
        u_host.open_frame(ID_OK, {OP_SETTING_TO_WIPER, 2'd2, 2'd0});
        u_host.close_frame();
        repeat (5) @(negedge i_clk);
        wiper_is(8'h00);
        repeat (30) @(negedge i_clk);
        wiper_is(8'h6c);
    endtask : t_transfer
    task automatic t_incdec();
        logic [7:0] tab [3][3];
        tab = '{'{8'hfe, 8'hff, 8'hff}, '{8'h03, 8'h00, 8'h00}, '{8'h10, 8'he0, 8'h0e}};
        for (int i = 0; i < 3; i++) begin
            set_wiper(tab[i][0]);
            u_host.frame(ID_OK, {OP_INC_DEC, 4'h0}, tab[i][1], 1'b1, rx);
            wiper_is(tab[i][2]);
        end
    endtask : t_incdec
    task automatic t_refuse();
        logic [7:0] ids [2];
        ids = '{{DEVICE_TYPE_FIELD, 4'h1}, {4'h6, 4'h2}};
        set_wiper(8'h21);
        for (int i = 0; i < 2; i++) begin
            u_host.frame(ids[i], {OP_WRITE_WIPER, 4'h0}, 8'h99, 1'b1, rx);
            wiper_is(8'h21);
            u_host.frame(ids[i], {OP_READ_WIPER, 4'h0}, 8'h00, 1'b1, rx);
            check(u_host.saw_drive, 1'b0);
        end
    endtask : t_refuse
    task automatic t_hold();
        u_host.open_frame(ID_OK, {OP_WRITE_WIPER, 4'h0});
        u_host.pause(3);
        u_host.byte_io(8'hc3, rx);
        u_host.close_frame();
        repeat (40) @(negedge i_clk);
        wiper_is(8'hc3);
    endtask : t_hold
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (8) @(negedge i_clk);
        wiper_is(DEFAULT_SETTING_RESET);
        check(o_so_oe, 1'b0);
        t_wiper();
        t_settings();
        t_protect();
        t_transfer();
        t_incdec();
        t_refuse();
        t_hold();
        summarize();
    end
endmodule : test_swcu_top
